/* File: src/sws_sequencer.sv */
`timescale 1ns/1ns
`include "sws_regs.svh"

// Operation
// - Kneepoint enable high lowers reset voltage on next shutter-begin.
// - In sync mode, each shutter-begin clears the integration time counter.
// - Stabilisation is five granulated ticks of 32 to 256 clocks.
// - Rolling mode: timeout pulses with the reset-row sync and load.
// - Rolling mode: frame-begin generates read-row sync and load.
// - Rolling mode: reset-row sync after exposure-length lines.
// - Column-load pulse overrides internal sync, loading column pointer.
// - Column-load held over two rising edges; captured on the first.
// - Each frame-begin triggers an amplifier frame calibration.
// - Global reset clears every internal register to zero.
// - Interface select and serial type decode; serial load active low.
// - Final-row flag during last line; pixel-valid during readout.
// - Pixel output valid five clocks after column sync.
module sws_sequencer (
  input  wire logic               clk,               // System pixel clock
  input  wire logic               rst,               // Global reset, high
  input  wire logic               shutter_mode,      // 1 rolling, 0 sync
  input  wire logic               shutter_begin,     // Shutter start strobe
  input  wire logic               shutter_end,       // Shutter stop strobe
  input  wire logic               frame_begin,       // Frame readout begin
  input  wire logic               line_advance,      // Line clock
  input  wire logic               col_load,          // Column pointer load
  input  wire logic [1:0]         kneepoint_sel,     // Reset voltage select
  input  wire logic               kneepoint_en,      // Lowered reset enable
  input  wire sws_pkg::sws_gran_t shutter_seq_granularity, // Tick factor
  input  wire sws_pkg::sws_cnt_t  exposure_length,   // Timer / lines
  input  wire sws_pkg::sws_cnt_t  line_count_limit,  // Lines per frame
  input  wire sws_pkg::sws_cnt_t  pixel_count_limit, // Pixels per line
  input  wire sws_pkg::sws_ptr_t  read_row_pointer,  // Read row start
  input  wire sws_pkg::sws_ptr_t  reset_row_pointer, // Reset row start
  input  wire sws_pkg::sws_ptr_t  col_pointer,       // Column start
  input  wire logic               if_select,         // 1 parallel
  input  wire logic               serial_type_select, // 1 three-wire
  input  wire logic               serial_load_n,     // Three-wire load
  output logic                    time_out,          // Exposure timeout
  output logic                    core_reset,        // Pixel reset phase
  output logic                    lowered_reset,     // Low reset voltage
  output logic [1:0]              reset_level,       // Voltage select
  output logic                    stable_ok,         // Upload allowed
  output logic                    core_readable,     // Readout state
  output sws_pkg::sws_cnt_t       integ_count,       // Integration timer
  output logic                    read_row_sync,     // Read row sync
  output sws_pkg::sws_ptr_t       read_row_ptr_q,    // Loaded read row
  output logic                    reset_row_sync,    // Reset row sync
  output sws_pkg::sws_ptr_t       reset_row_ptr_q,   // Loaded reset row
  output sws_pkg::sws_cnt_t       line_cnt,          // Current line
  output logic                    col_sync,          // Column sync
  output sws_pkg::sws_ptr_t       col_ptr_q,         // Loaded column
  output logic                    final_row_flag,    // Last line active
  output logic                    pixel_valid_flag,  // Pixel readout
  output logic                    pix_out_valid,     // Output sample ready
  output logic                    amp_calib,         // Frame calibration
  output logic                    iface_par,         // Parallel selected
  output logic                    iface_ser3,        // Three-wire selected
  output logic                    iface_ser2,        // Two-wire selected
  output logic                    ser3_load          // Three-wire load
);
  import sws_pkg::*;

  // ---------------------------------------------------------------
  // Strobe sampling
  // ---------------------------------------------------------------
  function automatic logic rose(input logic cur, input logic prev);
    rose = cur & ~prev;
  endfunction : rose

  logic start_q;
  logic stop_q;
  logic frame_q;
  logic line_q;
  logic load_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_q <= 1'b0;
      stop_q  <= 1'b0;
      frame_q <= 1'b0;
      line_q  <= 1'b0;
      load_q  <= 1'b0;
    end else begin
      start_q <= shutter_begin;
      stop_q  <= shutter_end;
      frame_q <= frame_begin;
      line_q  <= line_advance;
      load_q  <= col_load;
    end
  end

  wire start_fall = rose(start_q, shutter_begin);
  wire stop_fall  = rose(stop_q, shutter_end);
  wire frame_rise = rose(frame_begin, frame_q);
  wire line_rise  = rose(line_advance, line_q);
  wire line_fall  = rose(line_q, line_advance);
  wire load_rise  = rose(col_load, load_q);

  // ---------------------------------------------------------------
  // Interface selection decode
  // ---------------------------------------------------------------
  assign iface_par  = if_select;
  assign iface_ser3 = ~if_select & serial_type_select;
  assign iface_ser2 = ~if_select & ~serial_type_select;
  assign ser3_load  = iface_ser3 & ~serial_load_n;

  // ---------------------------------------------------------------
  // Synchronous shutter sequencer
  // ---------------------------------------------------------------
  sws_ss_state_e state;
  sws_ss_state_e next_state;
  logic [2:0]    phase_cnt;
  logic [2:0]    stable_cnt;
  logic          tick;

  sws_gran_div u_gran (
    .clk     (clk),
    .rst     (rst),
    .restart (state == SWS_ARM),
    .gran    (shutter_seq_granularity),
    .tick    (tick)
  );

  wire rst_done  = tick & (phase_cnt == `SWS_RESET_TICKS - 3'h1);
  wire prep_done = tick & (phase_cnt == `SWS_READY_TICKS - 3'h1);
  wire integ_hit = integ_count == exposure_length;

  // In sync mode, shutter-begin restarts from any state so multi-slope resets work
  always_comb begin
    next_state = state;
    if (!shutter_mode && shutter_begin) begin
      next_state = SWS_ARM;
    end else begin
      unique case (state)
        SWS_IDLE:  next_state = SWS_IDLE;
        SWS_ARM:   next_state = start_fall ? SWS_RSTP : SWS_IDLE;
        SWS_RSTP:  if (rst_done) next_state = SWS_INTEG;
        SWS_INTEG: if (tick && integ_hit) next_state = SWS_TOUT;
        SWS_TOUT:  if (tick) next_state = SWS_WSTOP;
        SWS_WSTOP: if (shutter_end) next_state = SWS_STOP;
        SWS_STOP:  if (stop_fall) next_state = SWS_PREP;
        SWS_PREP:  if (prep_done) next_state = SWS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= SWS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_cnt <= 3'h0;
    end else if (state != next_state) begin
      phase_cnt <= 3'h0;
    end else if (tick) begin
      phase_cnt <= phase_cnt + 3'h1;
    end
  end

  // Timer counts granulated ticks once the reset phase is over
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      integ_count <= `SWS_CNT_RESET;
    end else if (!shutter_mode && shutter_begin) begin
      integ_count <= `SWS_CNT_RESET;
    end else if (state == SWS_INTEG && tick && !integ_hit) begin
      integ_count <= integ_count + 12'h001;
    end
  end

  // Kneepoint bits are taken when shutter-begin ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowered_reset <= 1'b0;
      reset_level   <= 2'h0;
    end else if (state == SWS_ARM && start_fall) begin
      lowered_reset <= kneepoint_en;
      reset_level   <= kneepoint_sel;
    end
  end

  // Uploads before five ticks would disturb the running reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stable_cnt <= 3'h0;
    end else if (state == SWS_ARM) begin
      stable_cnt <= 3'h0;
    end else if (tick && stable_cnt != `SWS_STABLE_TICKS) begin
      stable_cnt <= stable_cnt + 3'h1;
    end
  end

  assign stable_ok     = stable_cnt == `SWS_STABLE_TICKS;
  assign core_reset    = state == SWS_RSTP;
  assign core_readable = state == SWS_IDLE;

  // ---------------------------------------------------------------
  // Rolling shutter row pointers and line count
  // ---------------------------------------------------------------
  wire [11:0] next_line = line_cnt + 12'h001;
  wire        expo_hit  = shutter_mode & line_rise
                          & (next_line == exposure_length);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_cnt        <= `SWS_CNT_RESET;
      read_row_sync   <= 1'b0;
      reset_row_sync  <= 1'b0;
      read_row_ptr_q  <= `SWS_PTR_RESET;
      reset_row_ptr_q <= `SWS_PTR_RESET;
      amp_calib       <= 1'b0;
    end else begin
      read_row_sync  <= frame_rise;
      reset_row_sync <= expo_hit;
      amp_calib      <= frame_rise;
      if (frame_rise) begin
        line_cnt       <= `SWS_CNT_RESET;
        read_row_ptr_q <= read_row_pointer;
      end else if (line_rise) begin
        line_cnt <= next_line;
      end
      if (expo_hit) begin
        reset_row_ptr_q <= reset_row_pointer;
      end
    end
  end

  // Rolling mode reuses the timeout pin to mark the reset-row sync
  assign time_out = shutter_mode ? reset_row_sync
                                 : (state == SWS_TOUT);

  // ---------------------------------------------------------------
  // Column sync, pixel readout and last line
  // ---------------------------------------------------------------
  logic [11:0]                 pix_cnt;
  logic [`SWS_PIX_LATENCY-1:0] pix_dly;

  wire next_col_sync = load_rise | (line_fall & ~col_load);
  wire pix_done      = pixel_valid_flag
                       & (pix_cnt == pixel_count_limit);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      col_sync         <= 1'b0;
      col_ptr_q        <= `SWS_PTR_RESET;
      pixel_valid_flag <= 1'b0;
      pix_cnt          <= `SWS_CNT_RESET;
      final_row_flag   <= 1'b0;
    end else begin
      col_sync <= next_col_sync;
      if (next_col_sync) begin
        col_ptr_q        <= col_pointer;
        pixel_valid_flag <= 1'b1;
        pix_cnt          <= `SWS_CNT_RESET;
      end else if (pix_done) begin
        pixel_valid_flag <= 1'b0;
      end else if (pixel_valid_flag) begin
        pix_cnt <= pix_cnt + 12'h001;
      end
      if (line_rise && next_line == line_count_limit) begin
        final_row_flag <= 1'b1;
      end else if (line_fall || frame_rise) begin
        final_row_flag <= 1'b0;
      end
    end
  end

  // Delay line keeps the sample strobe aligned to the analog pipe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pix_dly <= '0;
    end else begin
      pix_dly <= {pix_dly[`SWS_PIX_LATENCY-2:0], col_sync};
    end
  end

  assign pix_out_valid = pix_dly[`SWS_PIX_LATENCY-1];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence start_ends_s;
    state == SWS_ARM && start_fall && !shutter_begin;
  endsequence

  sequence reset_phase_s;
    core_reset [*1] ##1 core_reset;
  endsequence

  knee_lower_a: assert property (
    start_ends_s ##0 kneepoint_en |=> lowered_reset ##0 reset_phase_s)
    else $error("kneepoint enable not applied to reset");
  integ_clear_a: assert property (
    shutter_begin && !shutter_mode |=> integ_count == 12'h000)
    else $error("integration counter not cleared");
  stable_wait_a: assert property (
    start_ends_s |=> !stable_ok [*8])
    else $error("stable flag too early");
  row_timeout_a: assert property (
    shutter_mode && expo_hit |=> time_out
      && reset_row_ptr_q == $past(reset_row_pointer))
    else $error("reset row sync without timeout");
  read_sync_a: assert property (
    frame_rise |=> read_row_sync && line_cnt == 12'h000
      && read_row_ptr_q == $past(read_row_pointer))
    else $error("read row sync missing");
  expo_lines_a: assert property (
    reset_row_sync |-> line_cnt == exposure_length)
    else $error("reset row sync at wrong line");
  col_load_a: assert property (
    load_rise |=> col_sync && col_ptr_q == $past(col_pointer)
      && pixel_valid_flag)
    else $error("column load not taken");
  calib_a: assert property (
    frame_rise |=> amp_calib ##1 !amp_calib)
    else $error("frame calibration missing");
  pix_latency_a: assert property (
    col_sync |-> ##5 pix_out_valid)
    else $error("pixel output latency wrong");
  final_row_a: assert property (
    final_row_flag && line_fall |=> !final_row_flag)
    else $error("final row flag not cleared");

endmodule : sws_sequencer

/* File: src/sws_regs.svh */
`ifndef SWS_REGS_SVH
`define SWS_REGS_SVH

// ---------------------------------------------------------------
// Shutter sequencer timing, in granulated sequencer ticks
// ---------------------------------------------------------------
`define SWS_RESET_TICKS   3'h4
`define SWS_READY_TICKS   3'h2
`define SWS_STABLE_TICKS  3'h5

// ---------------------------------------------------------------
// Granularity divider terminal counts (factor minus one)
// ---------------------------------------------------------------
`define SWS_GRAN_X32      8'h1F
`define SWS_GRAN_X64      8'h3F
`define SWS_GRAN_X128     8'h7F
`define SWS_GRAN_X256     8'hFF

// ---------------------------------------------------------------
// Pixel output latency after column sync, in clocks
// ---------------------------------------------------------------
`define SWS_PIX_LATENCY   5

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SWS_CNT_RESET     12'h000
`define SWS_PTR_RESET     11'h000

`endif

/* File: src/sws_pkg.sv */
package sws_pkg;

  typedef logic [1:0]  sws_gran_t;
  typedef logic [11:0] sws_cnt_t;
  typedef logic [10:0] sws_ptr_t;

  typedef enum logic [2:0] {
    SWS_IDLE  = 3'b000,
    SWS_ARM   = 3'b001,
    SWS_RSTP  = 3'b010,
    SWS_INTEG = 3'b011,
    SWS_TOUT  = 3'b100,
    SWS_WSTOP = 3'b101,
    SWS_STOP  = 3'b110,
    SWS_PREP  = 3'b111
  } sws_ss_state_e;

endpackage : sws_pkg

/* File: src/sws_gran_div.sv */
`timescale 1ns/1ns
`include "sws_regs.svh"

module sws_gran_div (
  input  wire logic           clk,     // System clock
  input  wire logic           rst,     // Async reset, high
  input  wire logic           restart, // Hold divider at phase 0
  input  wire sws_pkg::sws_gran_t gran, // Granularity code
  output logic                tick     // One-cycle enable
);
  import sws_pkg::*;

  logic [7:0] cnt;
  wire  [7:0] last_cnt;
  wire        at_last;

  assign last_cnt = (gran == 2'h0) ? `SWS_GRAN_X32  :
                    (gran == 2'h1) ? `SWS_GRAN_X64  :
                    (gran == 2'h2) ? `SWS_GRAN_X128 : `SWS_GRAN_X256;
  assign at_last  = (cnt >= last_cnt);

  // Restart aligns the tick grid to the end of shutter-begin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (restart) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else begin
      cnt  <= at_last ? 8'h00 : cnt + 8'h01;
      tick <= at_last;
    end
  end

endmodule : sws_gran_div

/* File: verif/sws_ctrl_model.sv */
`timescale 1ns/1ns

module sws_ctrl_model (
  input  wire logic  clk,           // System clock
  input  wire logic  start,         // Run one sequence
  input  wire logic  time_out,      // Exposure timeout
  input  wire logic  stable_ok,     // Upload window open
  output logic       shutter_begin, // Shutter start
  output logic       shutter_end,   // Shutter stop
  output logic [1:0] kneepoint_sel, // Voltage select
  output logic       kneepoint_en,  // Lowered reset
  output logic       busy           // Sequence running
);
  // Parallel upload budget, 1 us
  localparam int UPLOAD = 125;

  task automatic wait_for(input logic lvl, input bit tmo, input int lim);
    for (int n = 0; n < lim && (tmo ? time_out : stable_ok) !== lvl; n++)
      @(negedge clk);
  endtask : wait_for

  // ----------------------------------------------------------
  // Multi-slope shutter sequence
  // ----------------------------------------------------------
  initial begin
    {shutter_begin, shutter_end, kneepoint_sel, kneepoint_en} = '0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (start === 1'b1) begin
        @(negedge clk);
        busy = 1'b1;
        for (int k = 1; k <= 4; k++) begin
          shutter_begin = 1'b1;
          repeat (2) @(negedge clk);
          shutter_begin = 1'b0;
          repeat (4) @(negedge clk);
          wait_for(1'b1, 1'b0, 1500);
          repeat (UPLOAD) @(negedge clk);
          kneepoint_sel = (k == 4) ? 2'b00 : 2'(k);
          kneepoint_en = (k != 4);
        end
        // Stop only once the timeout has ended, never tied to it
        wait_for(1'b1, 1'b1, 6000);
        wait_for(1'b0, 1'b1, 300);
        shutter_end = 1'b1;
        repeat (2) @(negedge clk);
        shutter_end = 1'b0;
        busy = 1'b0;
      end
    end
  end
endmodule : sws_ctrl_model

/* File: verif/shutter_window_sequencer_tb.sv */
`timescale 1ns/1ns

module shutter_window_sequencer_tb;
  import sws_pkg::*;

  logic       clk, rst, shutter_mode, shutter_begin, shutter_end;
  logic       frame_begin, line_advance, col_load, kneepoint_en;
  logic       if_select, serial_type_select, serial_load_n, start;
  logic       busy, time_out, core_reset, lowered_reset, stable_ok;
  logic       core_readable, read_row_sync, reset_row_sync, col_sync;
  logic       final_row_flag, pixel_valid_flag, pix_out_valid;
  logic       amp_calib, iface_par, iface_ser3, iface_ser2, ser3_load;
  logic [1:0] kneepoint_sel, reset_level;
  sws_gran_t  shutter_seq_granularity;
  sws_cnt_t   exposure_length, line_count_limit, pixel_count_limit;
  sws_cnt_t   integ_count, line_cnt;
  sws_ptr_t   read_row_pointer, reset_row_pointer, col_pointer;
  sws_ptr_t   read_row_ptr_q, reset_row_ptr_q, col_ptr_q;
  int         n_errors, check_count, lines, n_col, n_rrs, n_cr;
  int         sbc, tol, gn, pvc, n_st;
  logic [31:0] seed;
  logic [4:0] hist;
  logic       run, cr_d, sb_d, st_d;
  sws_ptr_t   cq[$];

  sws_sequencer uut (
    .clk, .rst, .shutter_mode, .shutter_begin, .shutter_end,
    .frame_begin, .line_advance, .col_load, .kneepoint_sel,
    .kneepoint_en, .shutter_seq_granularity, .exposure_length,
    .line_count_limit, .pixel_count_limit, .read_row_pointer,
    .reset_row_pointer, .col_pointer, .if_select, .serial_type_select,
    .serial_load_n, .time_out, .core_reset, .lowered_reset,
    .reset_level, .stable_ok, .core_readable, .integ_count,
    .read_row_sync, .read_row_ptr_q, .reset_row_sync, .reset_row_ptr_q,
    .line_cnt, .col_sync, .col_ptr_q, .final_row_flag,
    .pixel_valid_flag, .pix_out_valid, .amp_calib, .iface_par,
    .iface_ser3, .iface_ser2, .ser3_load
  );

  sws_ctrl_model ctrl (
    .clk, .start, .time_out, .stable_ok, .shutter_begin, .shutter_end,
    .kneepoint_sel, .kneepoint_en, .busy
  );

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // ----------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  function automatic logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic do_reset;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    chk_val(integ_count | line_cnt | 12'(col_ptr_q), 12'h000);
    chk_bit(time_out | core_reset | pixel_valid_flag, 1'b0);
    chk_bit(core_readable, 1'b1);
    rst = 1'b0;
  endtask : do_reset

  task automatic do_line(input bit ld);
    line_advance = 1'b1;
    lines++;
    repeat (2) @(negedge clk);
    chk_bit(final_row_flag, lines == int'(line_count_limit));
    cq.push_back(col_pointer);
    line_advance = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(final_row_flag, 1'b0);
    repeat (24) @(negedge clk);
    if (ld) begin
      col_pointer = 11'(rnd());
      repeat (40) @(negedge clk);
      cq.push_back(col_pointer);
      col_load = 1'b1;
      repeat (2) @(negedge clk);
      col_load = 1'b0;
      repeat (24) @(negedge clk);
    end
  endtask : do_line

  // ----------------------------------------------------------
  // Monitor, sampled where every signal is settled
  // ----------------------------------------------------------
  always @(posedge clk) begin
    if (run) begin
      chk_bit(pix_out_valid, hist[4]);
      if (col_sync === 1'b1) begin
        chk_val(12'(col_ptr_q), 12'(cq.pop_front()));
        chk_bit(pixel_valid_flag, 1'b1);
        n_col++;
      end
      // Valid spans the counter from zero up to the pixel limit
      if (pixel_valid_flag === 1'b1) begin
        pvc++;
      end else if (pvc > 0) begin
        chk_val(12'(pvc), pixel_count_limit + 12'h001);
        pvc = 0;
      end
      if (read_row_sync === 1'b1) begin
        chk_val(12'(read_row_ptr_q), 12'(read_row_pointer));
        chk_bit(amp_calib, 1'b1);
      end
      if (reset_row_sync === 1'b1) begin
        chk_val(12'(reset_row_ptr_q), 12'(reset_row_pointer));
        chk_val(12'(lines), exposure_length);
        chk_bit(time_out, 1'b1);
        n_rrs++;
      end
      if (core_reset === 1'b1 && cr_d !== 1'b1) begin
        chk_bit(lowered_reset, kneepoint_en);
        chk_val(12'(reset_level), 12'(kneepoint_sel));
        n_cr++;
      end
      if (stable_ok === 1'b1 && st_d !== 1'b1 && !shutter_mode) begin
        chk_bit(sbc >= 5 * gn - 3 && sbc <= 5 * gn + 3, 1'b1);
        n_st++;
      end
      if (shutter_begin === 1'b1 && sb_d === 1'b1)
        chk_val(integ_count, 12'h000);
      if (time_out === 1'b1 && !shutter_mode) begin
        tol++;
      end else if (tol > 0) begin
        chk_val(12'(tol), 12'(gn));
        tol = 0;
      end
      sbc = (shutter_begin === 1'b1) ? 0 : sbc + 1;
    end
    hist <= {hist[3:0], col_sync};
    cr_d <= core_reset;
    sb_d <= shutter_begin;
    st_d <= stable_ok;
  end

  // ----------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------
  initial begin
    {rst, shutter_mode, frame_begin, line_advance, col_load} = '0;
    {start, if_select, serial_type_select, serial_load_n} = 4'h1;
    shutter_seq_granularity = 2'h0;
    exposure_length = 12'h00C;
    line_count_limit = 12'h005;
    pixel_count_limit = 12'h008;
    {read_row_pointer, reset_row_pointer, col_pointer} = '0;
    {n_errors, check_count, lines, n_col, n_rrs, n_cr, sbc, tol} = '0;
    {run, hist} = '0;
    {pvc, n_st} = '0;
    gn = 32;
    seed = 32'h000083F5;
    @(negedge clk);
    do_reset;
    for (int i = 0; i < 8; i++) begin
      {if_select, serial_type_select, serial_load_n} = 3'(i);
      #1;
      chk_bit(iface_par, if_select);
      chk_bit(iface_ser3, !if_select && serial_type_select);
      chk_bit(iface_ser2, !if_select && !serial_type_select);
      chk_bit(ser3_load, iface_ser3 && !serial_load_n);
    end
    @(negedge clk);
    run = 1'b1;
    for (int g = 0; g < 4; g++) begin
      shutter_seq_granularity = 2'(g);
      gn = 32 << g;
      n_cr = 0;
      n_st = 0;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (2) @(negedge clk);
      for (int n = 0; n < 40000 && busy !== 1'b0; n++) @(negedge clk);
      for (int n = 0; n < 2000 && core_readable !== 1'b1; n++)
        @(negedge clk);
      // A run stuck before readout is counted here; one that keeps busy set trips the 40000-cycle watchdog first
      chk_bit(busy, 1'b0);
      chk_bit(core_readable, 1'b1);
      chk_val(12'(n_st), 12'h004);
      chk_val(12'(n_cr), 12'h004);
    end
    shutter_mode = 1'b1;
    exposure_length = 12'h003;
    for (int f = 0; f < 2; f++) begin
      read_row_pointer = 11'(rnd());
      reset_row_pointer = read_row_pointer;
      pixel_count_limit = 12'(4 + rnd() % 8);
      repeat (40) @(negedge clk);
      frame_begin = 1'b1;
      lines = 0;
      repeat (3) @(negedge clk);
      frame_begin = 1'b0;
      for (int i = 1; i <= 5; i++) do_line(i == 2);
    end
    chk_val(12'(n_rrs), 12'h002);
    chk_val(12'(n_col), 12'h00C);
    run = 1'b0;
    do_reset;
    end_sim;
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    end_sim;
  end
endmodule : shutter_window_sequencer_tb
